// File: dibit_fifo.sv
`timescale 1ns/1ps
module dibit_fifo #(
	parameter int unsigned WIDTH = 2,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] inData,
	input  wire logic             inValid,
	output logic                  inReady,
	output logic      [WIDTH-1:0] outData,
	output logic                  outValid,
	input  wire logic             outReady
);
	localparam int unsigned PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    wrPtr_reg;
	logic [PW-1:0]    rdPtr_reg;
	logic [PW:0]      count_reg;
	logic [PW:0]      count_next;
	logic             inReady_reg;
	wire              doPush = inValid && inReady_reg;
	wire              doPop  = outValid && outReady;

	assign outValid = (count_reg != '0);
	assign outData  = mem[rdPtr_reg];
	assign inReady  = inReady_reg;

	always_comb begin
		count_next = count_reg;
		if (doPush && !doPop) begin
			count_next = count_reg + 1'b1;
		end else if (doPop && !doPush) begin
			count_next = count_reg - 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (doPush) begin
			mem[wrPtr_reg] <= inData;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wrPtr_reg   <= '0;
			rdPtr_reg   <= '0;
			count_reg   <= '0;
			inReady_reg <= 1'b0;
		end else begin
			wrPtr_reg   <= doPush ? PW'((wrPtr_reg + 1'b1) % DEPTH) : wrPtr_reg;
			rdPtr_reg   <= doPop ? PW'((rdPtr_reg + 1'b1) % DEPTH) : rdPtr_reg;
			count_reg   <= count_next;
			inReady_reg <= (count_next != (PW+1)'(DEPTH));
		end
	end
endmodule : dibit_fifo

// File: mac_model.sv
`timescale 1ns/1ps
module mac_model (
	input  wire logic        refClk,
	input  wire logic        sendReq,
	input  wire logic [1:0]  rxd,
	input  wire logic        crsDv,
	output logic             txEn = 1'b0,
	output logic [1:0]       txd = 2'h0,
	output logic [7:0]       txCount = 8'h00,
	output logic [31:0]      rxLog = 32'h0
);
	// One dibit per ref period; idle data toggles
	always @(posedge refClk) begin
		txEn <= sendReq;
		txd <= sendReq ? txCount[1:0] : ~txd;
		if (sendReq) txCount <= txCount + 8'h01;
		if (crsDv) rxLog <= {rxLog[29:0], rxd};
	end
endmodule : mac_model

// File: rmii_phy_strap_led_logic.sv
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "rmii_strap_consts.svh"

// Functional notes
// - Mode field picks speed or activity indicator
// - Speed pin level latched into speed-select bit
// - Send receive dibit each period CRS_DV high
// - Accept transmit dibit each period TX_EN high
// - Station address latched from three strap pins
// - Station address bits four and three zero
// - Interface straps latched; code 001 selects RMII
module rmii_phy_strap_led_logic #(
	parameter int unsigned BLINK_CYCLES = `BLINK_CYCLES
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic                   chipRstN,
	input  wire logic [`ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [`ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	input  wire logic                   refClk,
	input  wire logic                   txEn,
	input  wire logic [1:0]             txd,
	output logic [1:0]                  rxd,
	output logic                        crsDv,
	input  wire logic                   station_addr_strap_b2,
	input  wire logic                   station_addr_strap_b1,
	input  wire logic                   station_addr_strap_b0,
	input  wire logic                   iface_select_strap_b2,
	input  wire logic                   iface_select_strap_b1,
	input  wire logic                   iface_select_strap_b0,
	input  wire logic                   speedPinIn,
	output logic                        second_indicator_out,
	output logic                        speedPinOe,
	input  wire logic [1:0]             rxDibitIn,
	input  wire logic                   rxDibitValid,
	output logic                        rxDibitReady,
	output logic [1:0]                  txDibitOut,
	output logic                        txDibitValid,
	output logic [`STATION_ADDR_W-1:0]  stationAddr,
	output logic                        rmiiSelected
);
	// Synchronised pins
	logic [1:0] txdSync;
	logic       txEnSync;
	logic       refSync;
	logic       chipRstNSync;
	logic [2:0] addrStrapSync;
	logic [2:0] ifaceStrapSync;
	logic       speedPinSync;

	sync_two_ff #(.WIDTH(4)) u_sync_link (
		.sys_clk (sys_clk),
		.asyncIn ({refClk, txEn, txd}),
		.syncOut ({refSync, txEnSync, txdSync})
	);

	sync_two_ff #(.WIDTH(8)) u_sync_strap (
		.sys_clk (sys_clk),
		.asyncIn ({chipRstN, speedPinIn,
		           station_addr_strap_b2, station_addr_strap_b1, station_addr_strap_b0,
		           iface_select_strap_b2, iface_select_strap_b1, iface_select_strap_b0}),
		.syncOut ({chipRstNSync, speedPinSync, addrStrapSync, ifaceStrapSync})
	);

	// Combined reset
	wire anyReset = rst || !chipRstNSync;

	// Reference clock edge detection
	logic refPrev_reg;
	wire  refRise = refSync && !refPrev_reg;
	wire  refFall = !refSync && refPrev_reg;

	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			// No false edge on leaving reset
			refPrev_reg <= refSync;
		end else begin
			refPrev_reg <= refSync;
		end
	end

	// Strap capture
	logic [2:0] addrStrap_reg;
	logic [2:0] ifaceStrap_reg;

	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			addrStrap_reg  <= addrStrapSync;
			ifaceStrap_reg <= ifaceStrapSync;
		end
	end

	wire [`STATION_ADDR_W-1:0] stationAddrNext = {`STATION_HI_ZERO, addrStrap_reg};
	wire rmiiSelNext = (ifaceStrap_reg == `IFACE_RMII);

	// Control register
	logic [1:0]  indMode_reg;
	logic        speedSel_reg;
	logic [31:0] txCount_reg;

	// Address decode shared by both channels
	function automatic logic isMapped(
		input logic [`ADDR_W-1:0] addr
	);
		isMapped = (addr == `CTRL_OFFSET)
		        || (addr == `STATUS_OFFSET)
		        || (addr == `TXCOUNT_OFFSET);
	endfunction : isMapped

	// Response code for one access
	function automatic logic [1:0] respFor(
		input logic mapped
	);
		respFor = mapped ? `RESP_OKAY : `RESP_SLVERR;
	endfunction : respFor

	// AXI write channel
	logic               awHeld_reg;
	logic               wHeld_reg;
	logic [`ADDR_W-1:0] awAddr_reg;
	logic [31:0]        wData_reg;
	logic [3:0]         wStrb_reg;
	logic               awReady_reg;
	logic               wReady_reg;
	logic               bValid_reg;
	logic [1:0]         bResp_reg;

	wire awTake = s_axi_awvalid && awReady_reg;
	wire wTake  = s_axi_wvalid && wReady_reg;
	wire haveAw = awHeld_reg || awTake;
	wire haveW  = wHeld_reg || wTake;
	wire [`ADDR_W-1:0] wrAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
	wire [31:0]        wrData = wHeld_reg ? wData_reg : s_axi_wdata;
	wire [3:0]         wrStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;
	wire doWrite = haveAw && haveW && !bValid_reg;
	wire wrCtrl  = doWrite && (wrAddr == `CTRL_OFFSET);
	wire wrMapped = isMapped(wrAddr);

	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			awHeld_reg  <= 1'b0;
			wHeld_reg   <= 1'b0;
			awAddr_reg  <= '0;
			wData_reg   <= '0;
			wStrb_reg   <= '0;
			awReady_reg <= 1'b0;
			wReady_reg  <= 1'b0;
			bValid_reg  <= 1'b0;
			bResp_reg   <= `RESP_OKAY;
		end else begin
			if (doWrite) begin
				awHeld_reg <= 1'b0;
				wHeld_reg  <= 1'b0;
				bValid_reg <= 1'b1;
				bResp_reg  <= respFor(wrMapped);
			end else begin
				awHeld_reg <= haveAw;
				wHeld_reg  <= haveW;
				if (bValid_reg && s_axi_bready) begin
					bValid_reg <= 1'b0;
				end
			end
			if (awTake) begin
				awAddr_reg <= s_axi_awaddr;
			end
			if (wTake) begin
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			awReady_reg <= !haveAw && !awReady_reg && !bValid_reg;
			wReady_reg  <= !haveW && !wReady_reg && !bValid_reg;
		end
	end

	// Control register update
	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			indMode_reg  <= `CTRL_IND_MODE_RST;
			speedSel_reg <= speedPinSync;
		end else if (wrCtrl && wrStrb[1]) begin
			indMode_reg  <= wrData[`CTRL_IND_MODE_HI:`CTRL_IND_MODE_LO];
			speedSel_reg <= wrData[`CTRL_SPEED_BIT];
		end
	end

	// AXI read channel
	logic        arReady_reg;
	logic        rValid_reg;
	logic [31:0] rData_reg;
	logic [1:0]  rResp_reg;
	logic        pinLevel_reg;

	wire arTake = s_axi_arvalid && arReady_reg;
	wire [31:0] ctrlWord = {16'h0000, indMode_reg, speedSel_reg, 13'h0000};
	wire [31:0] statWord = {18'h00000, pinLevel_reg, rmiiSelected, 1'b0,
	                        ifaceStrap_reg, 3'h0, stationAddr};
	wire rdCtrl  = (s_axi_araddr == `CTRL_OFFSET);
	wire rdStat  = (s_axi_araddr == `STATUS_OFFSET);
	wire rdCount = (s_axi_araddr == `TXCOUNT_OFFSET);
	wire [31:0] rdWord = rdCtrl ? ctrlWord : rdStat ? statWord : rdCount ? txCount_reg : 32'h0;

	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			arReady_reg <= 1'b0;
			rValid_reg  <= 1'b0;
			rData_reg   <= '0;
			rResp_reg   <= `RESP_OKAY;
		end else begin
			arReady_reg <= !arReady_reg && !rValid_reg && !s_axi_arvalid ? 1'b1 :
			               (!rValid_reg && !arReady_reg);
			if (arTake) begin
				arReady_reg <= 1'b0;
				rValid_reg  <= 1'b1;
				rData_reg   <= rdWord;
				rResp_reg   <= respFor(isMapped(s_axi_araddr));
			end else if (rValid_reg && s_axi_rready) begin
				rValid_reg <= 1'b0;
			end
		end
	end

	// Transmit sampling at mid-period
	wire txAccept = refFall && txEnSync && rmiiSelNext;

	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			txDibitOut   <= '0;
			txDibitValid <= 1'b0;
			txCount_reg  <= '0;
		end else begin
			txDibitValid <= txAccept;
			if (txAccept) begin
				txDibitOut  <= txdSync;
				txCount_reg <= txCount_reg + 32'h1;
			end
		end
	end

	// Receive path
	rmii_strap_pkg::dibit_t fifoData;
	logic                   fifoValid;
	wire                    rxPop = refRise && rmiiSelNext;

	dibit_fifo #(
		.WIDTH (`RX_FIFO_WIDTH),
		.DEPTH (`RX_FIFO_DEPTH)
	) u_rx_fifo (
		.sys_clk  (sys_clk),
		.rst      (anyReset),
		.inData   (rxDibitIn),
		.inValid  (rxDibitValid),
		.inReady  (rxDibitReady),
		.outData  (fifoData),
		.outValid (fifoValid),
		.outReady (rxPop)
	);

	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			rxd   <= '0;
			crsDv <= 1'b0;
		end else if (rxPop) begin
			crsDv <= fifoValid;
			rxd   <= fifoValid ? fifoData : 2'h0;
		end
	end

	// Activity blink timing
	logic [`BLINK_CNT_W-1:0] blinkCnt_reg;
	logic                    actSeen_reg;
	logic                    actLed_reg;
	wire blinkExpire = (blinkCnt_reg == `BLINK_CNT_W'(BLINK_CYCLES - 1));
	wire traffic     = txAccept || (rxPop && fifoValid);

	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			blinkCnt_reg <= '0;
			actSeen_reg  <= 1'b0;
			actLed_reg   <= 1'b1;
		end else begin
			blinkCnt_reg <= blinkExpire ? '0 : blinkCnt_reg + 1'b1;
			actSeen_reg  <= traffic || (actSeen_reg && !blinkExpire);
			if (blinkExpire) begin
				actLed_reg <= actSeen_reg ? !actLed_reg : 1'b1;
			end
		end
	end

	// Indicator selection
	logic indNext;

	always_comb begin
		case (rmii_strap_pkg::ind_mode_t'(indMode_reg))
			rmii_strap_pkg::IND_SPEED: begin
				indNext = !speedSel_reg;
			end
			rmii_strap_pkg::IND_ACTIVITY: begin
				indNext = actLed_reg;
			end
			default: begin
				indNext = 1'b1;
			end
		endcase
	end

	// Pin roles and status outputs
	always_ff @(posedge sys_clk) begin
		if (anyReset) begin
			second_indicator_out <= 1'b1;
			speedPinOe           <= 1'b0;
			stationAddr          <= '0;
			rmiiSelected         <= 1'b0;
			pinLevel_reg         <= 1'b1;
		end else begin
			second_indicator_out <= indNext;
			speedPinOe           <= 1'b1;
			stationAddr          <= stationAddrNext;
			rmiiSelected         <= rmiiSelNext;
			pinLevel_reg         <= indNext;
		end
	end

	assign s_axi_awready = awReady_reg;
	assign s_axi_wready  = wReady_reg;
	assign s_axi_bvalid  = bValid_reg;
	assign s_axi_bresp   = bResp_reg;
	assign s_axi_arready = arReady_reg;
	assign s_axi_rvalid  = rValid_reg;
	assign s_axi_rdata   = rData_reg;
	assign s_axi_rresp   = rResp_reg;
endmodule : rmii_phy_strap_led_logic

// File: rmii_phy_strap_led_logic_properties.sv
`timescale 1ns/1ps
`include "rmii_strap_consts.svh"
module rmii_phy_checker (
	input wire logic                      sys_clk,
	input wire logic                      rst,
	input wire logic                      chipRstN,
	input wire logic [1:0]                txd,
	input wire logic [1:0]                txDibitOut,
	input wire logic                      txDibitValid,
	input wire logic [1:0]                rxd,
	input wire logic                      crsDv,
	input wire logic                      station_addr_strap_b2,
	input wire logic                      station_addr_strap_b1,
	input wire logic                      station_addr_strap_b0,
	input wire logic                      iface_select_strap_b2,
	input wire logic                      iface_select_strap_b1,
	input wire logic                      iface_select_strap_b0,
	input wire logic                      speedPinOe,
	input wire logic [`STATION_ADDR_W-1:0] stationAddr,
	input wire logic                      rmiiSelected
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	wire [2:0] addrStrap = {station_addr_strap_b2, station_addr_strap_b1, station_addr_strap_b0};
	wire [2:0] ifaceStrap = {iface_select_strap_b2, iface_select_strap_b1, iface_select_strap_b0};

	AST_ADDR_HI: assert property (stationAddr[4:3] == `STATION_HI_ZERO)
		else $error("station address high bits not zero");
	AST_ADDR_LATCH: assert property ($fell(rst) && chipRstN
		|=> stationAddr[2:0] == addrStrap)
		else $error("station address not latched");
	AST_IFACE_LATCH: assert property ($fell(rst) && chipRstN
		|=> rmiiSelected == (ifaceStrap == `IFACE_RMII))
		else $error("interface select not latched");
	AST_OE: assert property ($fell(rst) && chipRstN |-> !speedPinOe ##1 speedPinOe)
		else $error("speed pin direction wrong around reset");
	AST_TX_PULSE: assert property (txDibitValid |=> !txDibitValid [*8])
		else $error("transmit dibit valid too long");
	AST_TX_DATA: assert property (txDibitValid |-> txDibitOut == $past(txd, 6))
		else $error("transmit dibit differs from pins");
	AST_GATE: assert property (!rmiiSelected |-> !txDibitValid && !crsDv)
		else $error("traffic without interface selected");
	AST_RX_HOLD: assert property ($changed({crsDv, rxd}) |=> $stable({crsDv, rxd}) [*8])
		else $error("receive dibit not held");
	AST_CHIP_RST: assert property (!chipRstN && !$past(chipRstN) && !$past(chipRstN, 2)
		|=> !speedPinOe && stationAddr == 5'h00)
		else $error("chip reset not holding logic");
	cover property (txDibitValid);
	cover property ($rose(crsDv));
	cover property ($fell(speedPinOe));
endmodule : rmii_phy_checker

bind rmii_phy_strap_led_logic rmii_phy_checker i_rmii_phy_checker (.sys_clk, .rst, .chipRstN,
	.txd, .txDibitOut, .txDibitValid, .rxd, .crsDv, .station_addr_strap_b2,
	.station_addr_strap_b1, .station_addr_strap_b0, .iface_select_strap_b2,
	.iface_select_strap_b1, .iface_select_strap_b0, .speedPinOe, .stationAddr, .rmiiSelected);

// File: rmii_strap_consts.svh
`ifndef RMII_STRAP_CONSTS_SVH
`define RMII_STRAP_CONSTS_SVH

// Clock
`define CLK_PERIOD_NS       4

// Register map, byte addresses
`define ADDR_W              8
`define CTRL_OFFSET         8'h00
`define STATUS_OFFSET       8'h04
`define TXCOUNT_OFFSET      8'h08

// Control register fields
`define CTRL_IND_MODE_HI    15
`define CTRL_IND_MODE_LO    14
`define CTRL_SPEED_BIT      13
`define CTRL_IND_MODE_RST   2'h0

// Status register fields
`define STAT_ADDR_HI        4
`define STAT_ADDR_LO        0
`define STAT_IFACE_HI       10
`define STAT_IFACE_LO       8
`define STAT_RMII_BIT       12
`define STAT_PIN_BIT        13

// Station address layout
`define STATION_ADDR_W      5
`define STATION_HI_ZERO     2'h0

// Interface select codes
`define IFACE_RMII          3'h1

// AXI responses
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

// Receive buffer
`define RX_FIFO_WIDTH       2
`define RX_FIFO_DEPTH       8

// Activity blink period
`define BLINK_TIME_MS       50
`define BLINK_CYCLES        ((`BLINK_TIME_MS * 1000000) / `CLK_PERIOD_NS)
`define BLINK_CNT_W         24

`endif

// File: rmii_strap_pkg.sv
package rmii_strap_pkg;

	typedef enum logic [1:0] {
		IND_SPEED    = 2'h0,
		IND_ACTIVITY = 2'h1,
		IND_RSVD2    = 2'h2,
		IND_RSVD3    = 2'h3
	} ind_mode_t;

	typedef logic [1:0] dibit_t;

endpackage : rmii_strap_pkg

// File: sync_two_ff.sv
`timescale 1ns/1ps
module sync_two_ff #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             sys_clk,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1_reg;

	// First stage read only by the second
	always_ff @(posedge sys_clk) begin
		stage1_reg <= asyncIn;
		syncOut    <= stage1_reg;
	end
endmodule : sync_two_ff

// File: testbench.sv
`timescale 1ns/1ps
`include "rmii_strap_consts.svh"
module testbench;
	typedef struct {
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] data;
		logic [3:0]  strb;
		logic [31:0] expData;
		logic [1:0]  expResp;
	} axi_row_t;
	logic        sys_clk = 1'b0, refClk = 1'b0, rst = 1'b1, chipRstN = 1'b1, speedStrap = 1'b1;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rxDibitValid = 1'b0, sendReq = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, txCount;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rxLog, rdat;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic [2:0]  addrStrap = 3'h5, ifaceStrap = 3'h1;
	logic [1:0]  rxDibitIn = 2'h0, s_axi_bresp, s_axi_rresp, rxd, txd, txDibitOut, resp;
	logic [1:0]  expTx = 2'h0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, lastInd;
	logic        crsDv, txEn, second_indicator_out, speedPinOe, rxDibitReady, txDibitValid;
	logic        rmiiSelected;
	logic [`STATION_ADDR_W-1:0] stationAddr;
	int          num_errors = 0, num_checks = 0, cyc = 0, txSeen = 0, indChanges = 0, n;
	wire         speedPin = (speedPinOe === 1'b1) ? second_indicator_out : speedStrap;
	axi_row_t    rows [15] = '{'{0, 8'h00, 0, 0, 32'h2000, 0}, '{1, 8'h00, 0, 4'hf, 0, 0},
		'{0, 8'h00, 0, 0, 0, 0}, '{0, 8'h04, 0, 0, 32'h3105, 0}, '{1, 8'h00, 32'h2000, 4'hf, 0, 0},
		'{0, 8'h04, 0, 0, 32'h1105, 0}, '{1, 8'h00, 32'hc000, 4'h1, 0, 0},
		'{0, 8'h00, 0, 0, 32'h2000, 0}, '{1, 8'h10, 0, 4'hf, 0, 2}, '{0, 8'h0c, 0, 0, 0, 2},
		'{1, 8'h00, 32'hc000, 4'hf, 0, 0}, '{0, 8'h04, 0, 0, 32'h3105, 0},
		'{1, 8'h04, 32'hffff, 4'hf, 0, 0}, '{1, 8'h00, 32'h6000, 4'hf, 0, 0},
		'{0, 8'h00, 0, 0, 32'h6000, 0}};

	always #2 sys_clk = ~sys_clk;
	always #62.5 refClk = ~refClk;

	rmii_phy_strap_led_logic #(.BLINK_CYCLES(64)) i_rmii_phy_strap_led_logic (.sys_clk, .rst,
		.chipRstN, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.refClk, .txEn, .txd, .rxd, .crsDv, .station_addr_strap_b2(addrStrap[2]),
		.station_addr_strap_b1(addrStrap[1]), .station_addr_strap_b0(addrStrap[0]),
		.iface_select_strap_b2(ifaceStrap[2]), .iface_select_strap_b1(ifaceStrap[1]),
		.iface_select_strap_b0(ifaceStrap[0]), .speedPinIn(speedPin), .second_indicator_out,
		.speedPinOe, .rxDibitIn, .rxDibitValid, .rxDibitReady, .txDibitOut, .txDibitValid,
		.stationAddr, .rmiiSelected);
	mac_model i_mac_model (.refClk, .sendReq, .rxd, .crsDv, .txEn, .txd, .txCount, .rxLog);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_read

	task final_report;
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : final_report

	always @(posedge sys_clk) begin
		cyc++;
		if (second_indicator_out !== lastInd) indChanges++;
		lastInd <= second_indicator_out;
		if (txDibitValid === 1'b1) begin
			chk(32'(txDibitOut), 32'(expTx));
			expTx <= expTx + 2'h1;
			txSeen++;
		end
		if (cyc == 40000) begin
			num_errors++;
			final_report;
		end
	end

	initial begin
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk(32'(stationAddr), 32'h5);
		chk(32'(rmiiSelected), 32'h1);
		chk(32'(speedPinOe), 32'h1);
		$display("reset straps done");
		for (int i = 0; i < 15; i++) begin
			if (rows[i].wr) axi_write(rows[i].addr, rows[i].data, rows[i].strb, resp);
			else begin
				axi_read(rows[i].addr, rdat, resp);
				chk(rdat, rows[i].expData);
			end
			chk(32'(resp), 32'(rows[i].expResp));
		end
		$display("register table done");
		indChanges = 0;
		sendReq <= 1'b1;
		repeat (200) @(posedge sys_clk);
		sendReq <= 1'b0;
		repeat (100) @(posedge sys_clk);
		chk(32'(txSeen), 32'(txCount));
		chk(32'(indChanges > 0), 32'h1);
		axi_read(8'h08, rdat, resp);
		chk(rdat, 32'(txCount));
		repeat (300) @(posedge sys_clk);
		chk(32'(second_indicator_out), 32'h1);
		$display("transmit and activity done");
		rxDibitValid <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			rxDibitIn <= i[1:0];
			do @(posedge sys_clk); while (rxDibitReady !== 1'b1);
		end
		rxDibitValid <= 1'b0;
		repeat (500) @(posedge sys_clk);
		chk(32'(rxLog[19:0]), 32'h1b1b1);
		chk(32'(crsDv), 32'h0);
		$display("receive done");
		addrStrap <= 3'h7;
		ifaceStrap <= 3'h2;
		speedStrap <= 1'b0;
		chipRstN <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chipRstN <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk(32'(stationAddr), 32'h7);
		chk(32'(rmiiSelected), 32'h0);
		chk(32'(second_indicator_out), 32'h1);
		axi_read(8'h00, rdat, resp);
		chk(rdat, 32'h0);
		n = 0;
		rxDibitValid <= 1'b1;
		for (int i = 0; i < 12; i++) begin
			@(posedge sys_clk);
			if (rxDibitReady === 1'b1) n++;
		end
		rxDibitValid <= 1'b0;
		chk(32'(n), 32'h8);
		$display("chip reset and buffer done");
		final_report;
	end
endmodule : testbench
